// [design/ssw_defines.svh]
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Clock and timing figures
`define SSW_CLK_MHZ           40
`define SSW_RESET_STRETCH_MS  200
`define SSW_BROWNOUT_MIN_MS   140
`define SSW_WD_TIMEOUT_MS     1600
`define SSW_STROBE_MIN_NS     50

////////////////////////////////////////////////////////////////////////////////
// Synchroniser bit positions
`define SSW_SYN_SUPPLY_LOW    0
`define SSW_SYN_PUSHBUTTON    1
`define SSW_SYN_STROBE        2
`define SSW_SYN_STROBE_DRIVEN 3
`define SSW_SYN_SENSE_LOW     4
`define SSW_SYN_WIDTH         5

// Safe reset view: supply low, button released, strobe floating, sense low
`define SSW_SYN_RESET_VAL     5'h13

`define SSW_COUNT_WIDTH       26

`endif

// [design/ssw_interval_timer.sv]
module ssw_interval_timer (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Control
  input  wire logic                clear,
  input  wire ssw_pkg::ssw_count_t limit,
  // Status
  output logic                     done
);

  ssw_pkg::ssw_count_t cnt_q;
  ssw_pkg::ssw_count_t cnt_d;
  logic                done_q;
  logic                done_d;

  // Saturating count, so done holds until the next clear
  always_comb begin
    if (clear) begin
      cnt_d = '0;
    end else begin
      cnt_d = ssw_pkg::ssw_sat_inc(cnt_q, limit);
    end
    done_d = !clear && (cnt_d == limit);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule : ssw_interval_timer

// [design/ssw_pkg.sv]
`include "ssw_defines.svh"

package ssw_pkg;

  typedef logic [`SSW_COUNT_WIDTH-1:0] ssw_count_t;
  typedef logic [`SSW_SYN_WIDTH-1:0]   ssw_syn_t;

  typedef enum logic [1:0] {
    PH_HOLD,
    PH_STRETCH,
    PH_RUN
  } ssw_phase_e;

  // Increment that stops at the limit
  function automatic ssw_count_t ssw_sat_inc(input ssw_count_t cnt, input ssw_count_t limit);
    ssw_count_t res;
    res = cnt;
    if (cnt < limit) begin
      res = cnt + ssw_count_t'(1);
    end
    return res;
  endfunction : ssw_sat_inc

endpackage : ssw_pkg

// [design/ssw_supervisor.sv]
`include "ssw_defines.svh"

module ssw_supervisor #(
  parameter int unsigned RESET_CYCLES = `SSW_RESET_STRETCH_MS * `SSW_CLK_MHZ * 1000,
  parameter int unsigned WD_CYCLES    = `SSW_WD_TIMEOUT_MS * `SSW_CLK_MHZ * 1000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Analog comparator results
  input  wire logic supplyLow,
  input  wire logic supplySenseBelowRef,
  // Host inputs
  input  wire logic pushbuttonResetN,
  input  wire logic watchdogStrobeIn,
  input  wire logic watchdogStrobeDriven,
  // Reset outputs
  output logic      rstOutN,
  output logic      rstOutP,
  // Watchdog and power-fail outputs
  output logic      watchdogExpiredN,
  output logic      supplyFailOutN
);

  localparam int unsigned BrownoutCycles =
    RESET_CYCLES * `SSW_BROWNOUT_MIN_MS / `SSW_RESET_STRETCH_MS;
  localparam int unsigned StrobeMinCycles =
    (`SSW_STROBE_MIN_NS * `SSW_CLK_MHZ + 999) / 1000;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  ssw_pkg::ssw_syn_t rawIn;
  ssw_pkg::ssw_syn_t syncIn;
  logic              supplyLowS;
  logic              pushS;
  logic              strobeS;
  logic              strobeDrivenS;
  logic              senseLowS;

  always_comb begin
    rawIn                         = '0;
    rawIn[`SSW_SYN_SUPPLY_LOW]    = supplyLow;
    rawIn[`SSW_SYN_PUSHBUTTON]    = pushbuttonResetN;
    rawIn[`SSW_SYN_STROBE]        = watchdogStrobeIn;
    rawIn[`SSW_SYN_STROBE_DRIVEN] = watchdogStrobeDriven;
    rawIn[`SSW_SYN_SENSE_LOW]     = supplySenseBelowRef;
  end

  ssw_sync u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .rawIn   (rawIn),
    .syncOut (syncIn)
  );

  assign supplyLowS    = syncIn[`SSW_SYN_SUPPLY_LOW];
  assign pushS         = syncIn[`SSW_SYN_PUSHBUTTON];
  assign strobeS       = syncIn[`SSW_SYN_STROBE];
  assign strobeDrivenS = syncIn[`SSW_SYN_STROBE_DRIVEN];
  assign senseLowS     = syncIn[`SSW_SYN_SENSE_LOW];

  //////////////////////////////////////////////////////////////////////////////
  // Reset sequencing

  ssw_pkg::ssw_phase_e phase_q;
  ssw_pkg::ssw_phase_e phase_d;
  logic                cause;
  logic                stretchClear;
  logic                stretchDone;
  logic                rstActive_d;
  logic                rstOutN_q;
  logic                rstOutP_q;

  // Supply low or pressed button both hold reset
  assign cause = supplyLowS || !pushS;

  // New cause in stretch restarts the full interval, covering both shorter minimums
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      ssw_pkg::PH_HOLD: begin
        if (!cause) begin
          phase_d = ssw_pkg::PH_STRETCH;
        end
      end
      ssw_pkg::PH_STRETCH: begin
        if (cause) begin
          phase_d = ssw_pkg::PH_HOLD;
        end else if (stretchDone) begin
          phase_d = ssw_pkg::PH_RUN;
        end
      end
      ssw_pkg::PH_RUN: begin
        if (cause) begin
          phase_d = ssw_pkg::PH_HOLD;
        end
      end
      default: begin
        phase_d = ssw_pkg::PH_HOLD;
      end
    endcase
    stretchClear = (phase_d != ssw_pkg::PH_STRETCH);
    rstActive_d  = (phase_d != ssw_pkg::PH_RUN);
  end

  ssw_interval_timer u_stretch (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (stretchClear),
    .limit (ssw_pkg::ssw_count_t'(RESET_CYCLES)),
    .done  (stretchDone)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q   <= ssw_pkg::PH_HOLD;
      rstOutN_q <= 1'b0;
      rstOutP_q <= 1'b1;
    end else begin
      phase_q   <= phase_d;
      rstOutN_q <= !rstActive_d;
      rstOutP_q <= rstActive_d;
    end
  end

  assign rstOutN = rstOutN_q;
  assign rstOutP = rstOutP_q;

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog

  logic strobePrev_q;
  logic strobePrev_d;
  logic strobeEdge;
  logic wdClear;
  logic wdDone;
  logic wdOutN_q;
  logic wdOutN_d;
  logic failOutN_q;
  logic failOutN_d;

  // Either edge counts; two samples cover the shortest legal pulse
  assign strobeEdge = strobeS ^ strobePrev_q;

  // Uses next reset state so a one-cycle dip clears expiry at once
  assign wdClear = rstActive_d || !strobeDrivenS || strobeEdge;

  ssw_interval_timer u_watchdog (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (wdClear),
    .limit (ssw_pkg::ssw_count_t'(WD_CYCLES)),
    .done  (wdDone)
  );

  always_comb begin
    strobePrev_d = strobeS;
    wdOutN_d     = !(wdDone || supplyLowS);
    failOutN_d   = !senseLowS;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strobePrev_q <= 1'b0;
      wdOutN_q     <= 1'b0;
      failOutN_q   <= 1'b0;
    end else begin
      strobePrev_q <= strobePrev_d;
      wdOutN_q     <= wdOutN_d;
      failOutN_q   <= failOutN_d;
    end
  end

  assign watchdogExpiredN = wdOutN_q;
  assign supplyFailOutN   = failOutN_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checking helpers

  ssw_pkg::ssw_count_t quietCnt_q;
  ssw_pkg::ssw_count_t quietCnt_d;
  ssw_pkg::ssw_count_t wdQuiet_q;
  ssw_pkg::ssw_count_t wdQuiet_d;
  logic [3:0]          strobeRun_q;
  logic [3:0]          strobeRun_d;

  // Cycles since the last reset cause, and since the last watchdog clear
  always_comb begin
    quietCnt_d  = cause ? '0 :
                  ssw_pkg::ssw_sat_inc(quietCnt_q, ssw_pkg::ssw_count_t'(RESET_CYCLES + 2));
    wdQuiet_d   = wdClear ? '0 :
                  ssw_pkg::ssw_sat_inc(wdQuiet_q, ssw_pkg::ssw_count_t'(WD_CYCLES + 2));
    strobeRun_d = (strobeS != strobePrev_q) ? 4'h1 :
                  ((strobeRun_q == 4'hF) ? strobeRun_q : strobeRun_q + 4'h1);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quietCnt_q  <= '0;
      wdQuiet_q   <= '0;
      strobeRun_q <= 4'h0;
    end else begin
      quietCnt_q  <= quietCnt_d;
      wdQuiet_q   <= wdQuiet_d;
      strobeRun_q <= strobeRun_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_edge_ok;
    strobeEdge && !supplyLowS ##1 !supplyLowS;
  endsequence

  sequence s_floating_ok;
    (!strobeDrivenS && !supplyLowS) [*2];
  endsequence

  property p_supply_hold;
    @(posedge mclk) disable iff (!rst_n)
    supplyLowS |=> !rstOutN;
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("reset not asserted after supply low");

  property p_push_hold;
    @(posedge mclk) disable iff (!rst_n)
    !pushS |=> !rstOutN && rstOutP;
  endproperty
  a_push_hold: assert property (p_push_hold)
    else $error("reset not asserted after pushbutton");

  property p_complement;
    @(posedge mclk) disable iff (!rst_n)
    rstOutP == !rstOutN;
  endproperty
  a_complement: assert property (p_complement)
    else $error("reset outputs not complementary");

  property p_release_exact;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rstOutN) |-> quietCnt_q == ssw_pkg::ssw_count_t'(RESET_CYCLES + 1);
  endproperty
  a_release_exact: assert property (p_release_exact)
    else $error("reset released at wrong time after cause removed");

  property p_release_bound;
    @(posedge mclk) disable iff (!rst_n)
    quietCnt_q == ssw_pkg::ssw_count_t'(RESET_CYCLES + 1) |-> rstOutN;
  endproperty
  a_release_bound: assert property (p_release_bound)
    else $error("reset still asserted after stretch interval");

  property p_min_pulse;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rstOutN) |-> quietCnt_q > ssw_pkg::ssw_count_t'(BrownoutCycles);
  endproperty
  a_min_pulse: assert property (p_min_pulse)
    else $error("reset pulse shorter than minimum after last cause");

  property p_wd_expire;
    @(posedge mclk) disable iff (!rst_n)
    wdQuiet_q == ssw_pkg::ssw_count_t'(WD_CYCLES + 1) |-> !watchdogExpiredN;
  endproperty
  a_wd_expire: assert property (p_wd_expire)
    else $error("watchdog did not expire on time");

  property p_wd_early;
    @(posedge mclk) disable iff (!rst_n)
    !$past(supplyLowS) && $past(wdQuiet_q) < ssw_pkg::ssw_count_t'(WD_CYCLES)
      |-> watchdogExpiredN;
  endproperty
  a_wd_early: assert property (p_wd_early)
    else $error("watchdog expired too early");

  property p_wd_floating;
    @(posedge mclk) disable iff (!rst_n)
    s_floating_ok |=> watchdogExpiredN;
  endproperty
  a_wd_floating: assert property (p_wd_floating)
    else $error("watchdog active while strobe floats");

  property p_wd_lowline;
    @(posedge mclk) disable iff (!rst_n)
    supplyLowS |=> !watchdogExpiredN;
  endproperty
  a_wd_lowline: assert property (p_wd_lowline)
    else $error("watchdog output high during supply low");

  property p_wd_release;
    @(posedge mclk) disable iff (!rst_n)
    $fell(supplyLowS) |=> watchdogExpiredN;
  endproperty
  a_wd_release: assert property (p_wd_release)
    else $error("watchdog output not released on supply recovery");

  property p_wd_edge;
    @(posedge mclk) disable iff (!rst_n)
    s_edge_ok |=> watchdogExpiredN;
  endproperty
  a_wd_edge: assert property (p_wd_edge)
    else $error("strobe edge did not clear watchdog");

  property p_short_pulse;
    @(posedge mclk) disable iff (!rst_n)
    strobeEdge && strobeRun_q >= 4'(StrobeMinCycles) |=> !wdDone;
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("short strobe pulse not recognised");

  property p_wd_hold;
    @(posedge mclk) disable iff (!rst_n)
    wdDone && !wdClear |=> wdDone;
  endproperty
  a_wd_hold: assert property (p_wd_hold)
    else $error("watchdog expiry dropped without clear");

endmodule : ssw_supervisor

// [design/ssw_sync.sv]
`include "ssw_defines.svh"

module ssw_sync (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Raw and synchronised levels
  input  wire ssw_pkg::ssw_syn_t rawIn,
  output ssw_pkg::ssw_syn_t      syncOut
);

  ssw_pkg::ssw_syn_t stage1_q;
  ssw_pkg::ssw_syn_t stage1_d;
  ssw_pkg::ssw_syn_t stage2_q;
  ssw_pkg::ssw_syn_t stage2_d;

  // First stage feeds only the second stage
  always_comb begin
    stage1_d = rawIn;
    stage2_d = stage1_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= `SSW_SYN_RESET_VAL;
      stage2_q <= `SSW_SYN_RESET_VAL;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign syncOut = stage2_q;

endmodule : ssw_sync

// [dv/ssw_host_model.sv]
module ssw_host_model #(
  parameter int unsigned KICK_CYCLES = 10
) (
  // Clock
  input  wire logic mclk,
  // Device outputs seen by the host
  input  wire logic rstOutN,
  input  wire logic watchdogExpiredN,
  // Bench controls
  input  wire logic kickEn,
  input  wire logic floatEn,
  input  wire logic pulseReq,
  input  wire logic wdLoop,
  input  wire logic benchButtonN,
  // Host pins toward the device
  output logic      watchdogStrobeIn,
  output logic      watchdogStrobeDriven,
  output logic      pushbuttonResetN
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        strobeLevel;
  logic        floatPattern;
  int unsigned kickCnt;

  initial begin
    strobeLevel  = 1'b0;
    floatPattern = 1'b0;
    kickCnt      = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic strobe, only while the processor is out of reset
  always @(negedge mclk) begin
    if (kickEn && rstOutN) begin
      if (kickCnt + 1 >= KICK_CYCLES) begin
        kickCnt     <= 0;
        strobeLevel <= ~strobeLevel;
      end else begin
        kickCnt <= kickCnt + 1;
      end
    end else begin
      kickCnt <= 0;
    end
  end

  // Floating pin toggles so a stale level never looks like a valid one
  always @(negedge mclk) begin
    floatPattern <= ~floatPattern;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign watchdogStrobeDriven = ~floatEn;
  assign watchdogStrobeIn     = floatEn ? floatPattern : (strobeLevel ^ pulseReq);
  assign pushbuttonResetN     = benchButtonN & (~wdLoop | watchdogExpiredN);
endmodule : ssw_host_model

// [dv/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned R  = 20;
  localparam int unsigned WD = 50;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic supplyLow = 1'b1;
  logic supplySenseBelowRef = 1'b1;
  logic kickEn = 1'b1;
  logic floatEn = 1'b0;
  logic pulseReq = 1'b0;
  logic wdLoop = 1'b0;
  logic benchButtonN = 1'b1;
  logic pushbuttonResetN;
  logic watchdogStrobeIn;
  logic watchdogStrobeDriven;
  logic rstOutN;
  logic rstOutP;
  logic watchdogExpiredN;
  logic supplyFailOutN;
  int   fails = 0;
  int   totalChecks = 0;

  always #12.5 mclk = ~mclk;

  ssw_supervisor #(.RESET_CYCLES(R), .WD_CYCLES(WD)) ssw_supervisor_i (
    .mclk(mclk), .rst_n(rst_n), .supplyLow(supplyLow),
    .supplySenseBelowRef(supplySenseBelowRef), .pushbuttonResetN(pushbuttonResetN),
    .watchdogStrobeIn(watchdogStrobeIn), .watchdogStrobeDriven(watchdogStrobeDriven),
    .rstOutN(rstOutN), .rstOutP(rstOutP), .watchdogExpiredN(watchdogExpiredN),
    .supplyFailOutN(supplyFailOutN));

  ssw_host_model #(.KICK_CYCLES(10)) ssw_host_model_i (
    .mclk(mclk), .rstOutN(rstOutN), .watchdogExpiredN(watchdogExpiredN),
    .kickEn(kickEn), .floatEn(floatEn), .pulseReq(pulseReq), .wdLoop(wdLoop),
    .benchButtonN(benchButtonN), .watchdogStrobeIn(watchdogStrobeIn),
    .watchdogStrobeDriven(watchdogStrobeDriven), .pushbuttonResetN(pushbuttonResetN));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic step;
    @(negedge mclk);
  endtask : step

  // Low time of the reset output, complement checked on every cycle
  task automatic measure_low(output int n);
    n = 0;
    while (rstOutN !== 1'b1 && n < 1000) begin
      check(rstOutP, !rstOutN, "reset complement");
      step;
      n++;
    end
  endtask : measure_low

  task automatic in_range(input int n, input int lo, input int hi, input string msg);
    check(n >= lo && n <= hi, 1, msg);
  endtask : in_range

  task automatic brownout;
    supplyLow = 1'b1;
    repeat (3) step;
    check(rstOutN, 1'b0, "reset on supply low");
    check(watchdogExpiredN, 1'b0, "watchdog out on supply low");
    supplyLow = 1'b0;
  endtask : brownout

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_power_up;
    int n;
    repeat (5) step;
    check(rstOutN, 1'b0, "reset held at low supply");
    check(watchdogExpiredN, 1'b0, "watchdog out at low supply");
    supplyLow = 1'b0;
    repeat (4) step;
    check(watchdogExpiredN, 1'b1, "watchdog out released at once");
    check(rstOutN, 1'b0, "reset still stretched");
    measure_low(n);
    in_range(n + 4, R, R + 4, "power-up stretch");
  endtask : t_power_up

  task automatic t_brownout;
    int n;
    brownout();
    measure_low(n);
    in_range(n, R, R + 4, "brownout stretch");
  endtask : t_brownout

  task automatic t_nested;
    int n;
    brownout();
    repeat (R / 2) step;
    check(rstOutN, 1'b0, "first pulse running");
    brownout();
    measure_low(n);
    in_range(n, R, R + 4, "second dip extends pulse");
  endtask : t_nested

  task automatic t_button;
    int n;
    benchButtonN = 1'b0;
    repeat (3) step;
    check(rstOutN, 1'b0, "button asserts reset");
    benchButtonN = 1'b1;
    repeat (2) step;
    benchButtonN = 1'b0;
    repeat (3) step;
    benchButtonN = 1'b1;
    measure_low(n);
    in_range(n, R, R + 4, "single stretched pulse after bounce");
  endtask : t_button

  task automatic t_wd_expiry;
    int n;
    kickEn = 1'b0;
    benchButtonN = 1'b0;
    repeat (3) step;
    benchButtonN = 1'b1;
    measure_low(n);
    n = 0;
    while (watchdogExpiredN === 1'b1 && n < 1000) begin
      step;
      n++;
    end
    in_range(n, WD - 1, WD + 3, "watchdog timeout from release");
    repeat (20) step;
    check(watchdogExpiredN, 1'b0, "expired output holds");
    pulseReq = 1'b1;
    repeat (2) step;
    pulseReq = 1'b0;
    repeat (4) step;
    check(watchdogExpiredN, 1'b1, "short strobe pulse clears");
    kickEn = 1'b1;
  endtask : t_wd_expiry

  task automatic t_kick;
    int lows;
    lows = 0;
    repeat (3 * WD) begin
      step;
      if (watchdogExpiredN !== 1'b1) lows++;
    end
    check(lows, 0, "regular strobing keeps watchdog quiet");
  endtask : t_kick

  task automatic t_float;
    int lows;
    int n;
    lows = 0;
    kickEn = 1'b0;
    floatEn = 1'b1;
    repeat (3 * WD) begin
      step;
      if (watchdogExpiredN !== 1'b1) lows++;
    end
    check(lows, 0, "floating strobe disables watchdog");
    brownout();
    measure_low(n);
    floatEn = 1'b0;
    kickEn = 1'b1;
  endtask : t_float

  task automatic t_power_fail;
    logic [3:0] pat;
    pat = 4'hA;
    for (int i = 0; i < 4; i++) begin
      supplySenseBelowRef = pat[i];
      repeat (3) step;
      check(supplyFailOutN, !pat[i], "power-fail output");
    end
  endtask : t_power_fail

  task automatic t_loop;
    int n;
    wdLoop = 1'b1;
    kickEn = 1'b0;
    n = 0;
    while (rstOutN === 1'b1 && n < 1000) begin
      step;
      n++;
    end
    check(rstOutN, 1'b0, "watchdog wired to button resets");
    wdLoop = 1'b0;
    kickEn = 1'b1;
    measure_low(n);
  endtask : t_loop

  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (10) step;
    rst_n = 1'b1;
    t_power_up();
    t_kick();
    t_brownout();
    t_nested();
    t_button();
    t_wd_expiry();
    t_float();
    t_power_fail();
    t_loop();
    close_out();
  end

  // Hang guard, well past the several hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    close_out();
  end
endmodule : testbench
